//--- lane_cfg.svh
`ifndef LANE_CFG_SVH
`define LANE_CFG_SVH

// **********
// Timing
// **********
`define CLK_NS          100
`define NS_PER_MS       1000000
`define REF_PERIOD_NS   800
`define LOCK_MS         2
`define LOCK_FIRST_MS   100
`define LOCK_EDGES      5'h10
`define HOST_LOCK_EDGES 5'h18
`define WAKE_EDGES      5'h04
`define REF_LOSS_CYC    6'h20
`define HOST_SAMPLE_PH  3'h2
`define WAKE_FILL       8'h00

// **********
// Rate ranges
// **********
`define RATIO_A         5'h0F
`define RATIO_B         5'h1E

// **********
// Device registers and fields
// **********
`define REG_CTRL        5'h00
`define REG_STAT        5'h04
`define REG_ISTAT       5'h08
`define REG_IEN         5'h0C
`define REG_ICLR        5'h10
`define CTRL_HD         0
`define CTRL_UP         1
`define CTRL_RANGE      2
`define INT_LOCK        0
`define INT_TMO         1
`define INT_WAKE        2
`define INT_DERR        3

`endif

//--- lane_pkg.sv
`default_nettype none
package lane_pkg;

   typedef logic [9:0]  sym_type;
   typedef logic [7:0]  byte_type;
   typedef logic [15:0] word_type;

   typedef struct packed {
      logic    rd;
      sym_type sym;
   } enc_res_type;

   typedef struct packed {
      logic     err;
      byte_type data;
   } dec_res_type;

   localparam logic [5:0] ENC6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] ENC4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   // Only unbalanced groups and the two balanced ones with two forms flip.
   function automatic enc_res_type enc_sym(input byte_type d, input logic rd);
      logic [5:0]  c6;
      logic [3:0]  c4;
      logic        r;
      enc_res_type res;
      c6 = ENC6[d[4:0]];
      r  = rd;
      if (rd && (($countones(c6) != 3) || (d[4:0] == 5'h07)))
         c6 = ~c6;
      if ($countones(c6) != 3)
         r = ~r;
      c4 = ENC4[d[7:5]];
      if (r && (($countones(c4) != 2) || (d[7:5] == 3'h3)))
         c4 = ~c4;
      if ($countones(c4) != 2)
         r = ~r;
      res.rd  = r;
      res.sym = {c6, c4};
      return res;
   endfunction : enc_sym

   function automatic dec_res_type dec_sym(input sym_type s);
      logic        f6;
      logic        f4;
      dec_res_type res;
      f6  = 1'b0;
      f4  = 1'b0;
      res = '0;
      for (int i = 0; i < 32; i++)
      begin
         if ((s[9:4] == ENC6[i]) || ((s[9:4] == ~ENC6[i]) &&
             (($countones(ENC6[i]) != 3) || (i == 7))))
         begin
            res.data[4:0] = 5'(i);
            f6 = 1'b1;
         end
      end
      for (int j = 0; j < 8; j++)
      begin
         if ((s[3:0] == ENC4[j]) || ((s[3:0] == ~ENC4[j]) &&
             (($countones(ENC4[j]) != 2) || (j == 3))))
         begin
            res.data[7:5] = 3'(j);
            f4 = 1'b1;
         end
      end
      res.err = ~(f6 & f4);
      return res;
   endfunction : dec_sym

endpackage : lane_pkg
`default_nettype wire

//--- lane_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lane_if;
   logic             ref_clk;
   logic             ref_oe;
   lane_pkg::sym_type h_sym0;
   lane_pkg::sym_type h_sym1;
   lane_pkg::sym_type d_sym0;
   lane_pkg::sym_type d_sym1;
   logic             h_oe0;
   logic             h_oe1;
   logic             d_oe0;
   logic             d_oe1;
   logic             ref_line;
   logic             act0;
   logic             act1;
   lane_pkg::sym_type lane0;
   lane_pkg::sym_type lane1;

   // A lane with no driver reads as electrical idle: no amplitude.
   assign ref_line = ref_oe & ref_clk;
   assign act0     = h_oe0 | d_oe0;
   assign act1     = h_oe1 | d_oe1;
   assign lane0    = h_oe0 ? h_sym0 : d_sym0;
   assign lane1    = h_oe1 ? h_sym1 : d_sym1;

   modport host_mp (output ref_clk, ref_oe, h_sym0, h_sym1, h_oe0, h_oe1,
                    input lane0, lane1, act0, act1);
   modport dev_mp  (output d_sym0, d_sym1, d_oe0, d_oe1,
                    input ref_line, lane0, lane1, act0, act1);
endinterface : lane_if
`default_nettype wire

//--- lane_host_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "lane_cfg.svh"
module lane_host_end
#(
   parameter int LOCK_FIRST_CYC = `LOCK_FIRST_MS * `NS_PER_MS / `CLK_NS
)(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   lane_if.host_mp                link,
   input  wire logic              half_duplex_i,
   input  wire logic              dir_up_i,
   input  wire logic              range_b_i,
   input  wire logic              dormant_req_i,
   input  wire lane_pkg::word_type tx_data_i,
   input  wire logic              tx_valid_i,
   output logic                   tx_ready_o,
   output lane_pkg::word_type     rx_data_o,
   output logic [1:0]             rx_valid_o,
   output logic                   rx_err_o,
   output logic                   locked_o,
   output logic                   lock_fail_o,
   output logic                   wake_o,
   output logic [4:0]             ratio_o
);
   import lane_pkg::*;

   localparam logic [2:0] REF_HALF = 3'(`REF_PERIOD_NS / `CLK_NS / 2);
   localparam logic [2:0] REF_LAST = 3'(`REF_PERIOD_NS / `CLK_NS - 1);

   typedef struct packed {
      logic [2:0]  cnt;
      logic        ref_q;
      logic        run;
      logic        locked;
      logic        first_done;
      logic        fail;
      logic [4:0]  edges;
      logic [19:0] tmr;
      logic        range_b;
      logic        rd0;
      logic        rd1;
      sym_type     sym0;
      sym_type     sym1;
      logic        oe0;
      logic        oe1;
      logic [10:0] l0_s1;
      logic [10:0] l0_s2;
      logic [10:0] l1_s1;
      logic [10:0] l1_s2;
      logic        amp1_d;
      logic        wake;
      word_type    rx_data;
      logic [1:0]  rx_valid;
      logic        rx_err;
   } host_state_type;

   host_state_type state_ff;
   host_state_type nxt_state;
   enc_res_type    enc0;
   enc_res_type    enc1;
   dec_res_type    dec0;
   dec_res_type    dec1;
   logic           hd;
   logic           out_ok;
   logic           in0;
   logic           in1;
   logic           tx_slot;

   assign hd      = half_duplex_i;
   // RULE2: lane roles
   assign out_ok  = ~(hd & dir_up_i);
   assign in0     = hd & dir_up_i;
   assign in1     = ~(hd & ~dir_up_i);
   assign tx_slot = state_ff.run & (state_ff.cnt == REF_HALF);
   // RULE4: encode and decode
   assign enc0    = enc_sym(state_ff.locked ? tx_data_i[7:0] : `WAKE_FILL,
                            state_ff.rd0);
   assign enc1    = enc_sym(tx_data_i[15:8], state_ff.rd1);
   assign dec0    = dec_sym(state_ff.l0_s2[9:0]);
   assign dec1    = dec_sym(state_ff.l1_s2[9:0]);

   always_comb
   begin
      nxt_state          = state_ff;
      nxt_state.l0_s1    = {link.act0, link.lane0};
      nxt_state.l0_s2    = state_ff.l0_s1;
      nxt_state.l1_s1    = {link.act1, link.lane1};
      nxt_state.l1_s2    = state_ff.l1_s1;
      nxt_state.amp1_d   = state_ff.l1_s2[10];
      nxt_state.rx_valid = 2'h0;
      nxt_state.rx_err   = 1'b0;
      // RULE15: optional detector
      nxt_state.wake     = in1 & state_ff.l1_s2[10] & ~state_ff.amp1_d;
      // **********
      // Reference clock divider
      // **********
      // RULE5: fixed divider
      if (state_ff.run)
         nxt_state.cnt = (state_ff.cnt == REF_LAST) ? 3'h0 : state_ff.cnt + 3'h1;
      // RULE6: no stop mid-traffic
      if (state_ff.run && dormant_req_i && !tx_valid_i && state_ff.cnt == REF_LAST)
      begin
         // RULE13: whole link dormant
         nxt_state.run     = 1'b0;
         nxt_state.locked  = 1'b0;
         nxt_state.edges   = 5'h00;
         // RULE9: back to low range
         nxt_state.range_b = 1'b0;
      end
      else if (!state_ff.run && !dormant_req_i)
      begin
         nxt_state.run = 1'b1;
         nxt_state.cnt = 3'h0;
      end
      // RULE12: no slowed clock
      nxt_state.ref_q = nxt_state.run & (nxt_state.cnt < REF_HALF);
      // **********
      // Lock
      // **********
      if (state_ff.run && !state_ff.locked && state_ff.cnt == 3'h0)
      begin
         nxt_state.edges = state_ff.edges + 5'h01;
         if (state_ff.edges == `HOST_LOCK_EDGES)
         begin
            nxt_state.locked     = 1'b1;
            nxt_state.first_done = 1'b1;
         end
      end
      // RULE11: first lock bound
      if (!state_ff.first_done && !state_ff.locked)
      begin
         if (state_ff.tmr != 20'(LOCK_FIRST_CYC))
            nxt_state.tmr = state_ff.tmr + 20'h00001;
         else
            nxt_state.fail = 1'b1;
      end
      // RULE8: range only between transfers
      if (state_ff.locked && !tx_valid_i && range_b_i != state_ff.range_b)
      begin
         nxt_state.range_b = range_b_i;
         nxt_state.locked  = 1'b0;
         nxt_state.edges   = 5'h00;
      end
      // **********
      // Transmit and receive
      // **********
      if (tx_slot)
      begin
         nxt_state.oe0 = 1'b0;
         nxt_state.oe1 = 1'b0;
         // RULE14: wake burst on lane0
         if (out_ok && ((state_ff.locked && tx_valid_i) ||
             (!state_ff.locked && state_ff.edges < `WAKE_EDGES)))
         begin
            nxt_state.sym0 = enc0.sym;
            nxt_state.rd0  = enc0.rd;
            nxt_state.oe0  = 1'b1;
            // RULE3: both lanes downstream
            if (hd && state_ff.locked)
            begin
               nxt_state.sym1 = enc1.sym;
               nxt_state.rd1  = enc1.rd;
               nxt_state.oe1  = 1'b1;
            end
         end
      end
      if (!state_ff.run)
      begin
         nxt_state.oe0 = 1'b0;
         nxt_state.oe1 = 1'b0;
      end
      if (state_ff.locked && state_ff.cnt == `HOST_SAMPLE_PH)
      begin
         if (in0 && state_ff.l0_s2[10])
         begin
            nxt_state.rx_data[7:0] = dec0.data;
            nxt_state.rx_valid[0]  = 1'b1;
            nxt_state.rx_err       = dec0.err;
         end
         if (in1 && state_ff.l1_s2[10])
         begin
            if (in0)
            begin
               nxt_state.rx_data[15:8] = dec1.data;
               nxt_state.rx_valid[1]   = 1'b1;
            end
            else
            begin
               nxt_state.rx_data[7:0] = dec1.data;
               nxt_state.rx_valid[0]  = 1'b1;
            end
            nxt_state.rx_err = nxt_state.rx_err | dec1.err;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign link.ref_clk = state_ff.ref_q;
   assign link.ref_oe  = state_ff.run;
   assign link.h_sym0  = state_ff.sym0;
   assign link.h_sym1  = state_ff.sym1;
   assign link.h_oe0   = state_ff.oe0;
   assign link.h_oe1   = state_ff.oe1;
   assign tx_ready_o   = tx_slot & state_ff.locked & out_ok;
   assign rx_data_o    = state_ff.rx_data;
   assign rx_valid_o   = state_ff.rx_valid;
   assign rx_err_o     = state_ff.rx_err;
   assign locked_o     = state_ff.locked;
   assign lock_fail_o  = state_ff.fail;
   assign wake_o       = state_ff.wake;
   assign ratio_o      = state_ff.range_b ? `RATIO_B : `RATIO_A;
endmodule : lane_host_end
`default_nettype wire

//--- lane_dev_end.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lane_cfg.svh"
// Functional notes
// RULE1: any reference period above sampling limit works; device takes a level held over REF_LOSS_CYC clocks as clock gone
// RULE2: lane0 downstream, lane1 upstream by default
// RULE3: half duplex drives both lanes one way
// RULE4: encode before send, decode after receive
// RULE5: host sources steady reference clock
// RULE6: host never stops clock mid transfer
// RULE7: device multiplies reference into bit clock
// RULE8: ratio fifteen low range, thirty high
// RULE9: after power down start in low range
// RULE10: relock within two milliseconds
// RULE11: first lock within one hundred milliseconds
// RULE12: host never slows clock below minimum
// RULE13: lanes idle singly or whole link dormant
// RULE14: amplitude detector wakes own port
// RULE15: device lane0 detector mandatory, host optional
// RULE16: ignore received symbols until locked
module lane_dev_end
#(
   parameter int LOCK_CYC       = `LOCK_MS * `NS_PER_MS / `CLK_NS,
   parameter int LOCK_FIRST_CYC = `LOCK_FIRST_MS * `NS_PER_MS / `CLK_NS
)(
   input  wire logic               clk_sys_i,
   input  wire logic               rst_n_i,
   lane_if.dev_mp                  link,
   input  wire logic [4:0]         addr_i,
   input  wire logic [31:0]        wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output logic [31:0]             rdata_o,
   output logic                    irq_o,
   input  wire lane_pkg::word_type tx_data_i,
   input  wire logic               tx_valid_i,
   output logic                    tx_ready_o,
   output lane_pkg::word_type      rx_data_o,
   output logic [1:0]              rx_valid_o,
   output logic                    locked_o,
   output logic [4:0]              ratio_o
);
   import lane_pkg::*;

   typedef struct packed {
      logic        ref_s1;
      logic        ref_s2;
      logic        ref_s3;
      logic [10:0] l0_s1;
      logic [10:0] l0_s2;
      logic [10:0] l1_s1;
      logic [10:0] l1_s2;
      logic        amp0_d;
      logic        locked;
      logic        first_done;
      logic        timed_out;
      logic        dormant;
      logic [4:0]  edges;
      logic [19:0] tmr;
      logic [5:0]  loss;
      logic        rd0;
      logic        rd1;
      sym_type     sym0;
      sym_type     sym1;
      logic        oe0;
      logic        oe1;
      word_type    rx_data;
      logic [1:0]  rx_valid;
      logic [2:0]  ctrl;
      logic [3:0]  istat;
      logic [3:0]  ien;
      logic [31:0] rdata;
   } dev_state_type;

   dev_state_type state_ff;
   dev_state_type nxt_state;
   enc_res_type   enc0;
   enc_res_type   enc1;
   dec_res_type   dec0;
   dec_res_type   dec1;
   logic          ref_rise;
   logic          hd;
   logic          up;
   logic          out_ok;
   logic          in0;
   logic          in1;
   logic [19:0]   limit;
   logic [3:0]    ev;
   logic [3:0]    clr;

   // RULE1: edges found by sampling
   assign ref_rise = state_ff.ref_s2 & ~state_ff.ref_s3;
   assign hd       = state_ff.ctrl[`CTRL_HD];
   assign up       = state_ff.ctrl[`CTRL_UP];
   // RULE2: default lane roles
   assign out_ok   = ~(hd & ~up);
   assign in0      = ~(hd & up);
   assign in1      = hd & ~up;
   // RULE10: relock bound
   assign limit    = state_ff.first_done ? 20'(LOCK_CYC) : 20'(LOCK_FIRST_CYC);
   // RULE4: encode and decode
   assign enc0     = enc_sym(tx_data_i[7:0], state_ff.rd0);
   assign enc1     = enc_sym(hd ? tx_data_i[15:8] : tx_data_i[7:0], state_ff.rd1);
   assign dec0     = dec_sym(state_ff.l0_s2[9:0]);
   assign dec1     = dec_sym(state_ff.l1_s2[9:0]);

   always_comb
   begin
      nxt_state          = state_ff;
      ev                 = 4'h0;
      clr                = 4'h0;
      nxt_state.ref_s1   = link.ref_line;
      nxt_state.ref_s2   = state_ff.ref_s1;
      nxt_state.ref_s3   = state_ff.ref_s2;
      nxt_state.l0_s1    = {link.act0, link.lane0};
      nxt_state.l0_s2    = state_ff.l0_s1;
      nxt_state.l1_s1    = {link.act1, link.lane1};
      nxt_state.l1_s2    = state_ff.l1_s1;
      nxt_state.amp0_d   = state_ff.l0_s2[10];
      nxt_state.rx_valid = 2'h0;
      nxt_state.rdata    = 32'h00000000;
      // **********
      // Dormant entry and wakeup
      // **********
      if (state_ff.ref_s2 != state_ff.ref_s3)
         nxt_state.loss = 6'h00;
      else if (state_ff.loss != `REF_LOSS_CYC)
         nxt_state.loss = state_ff.loss + 6'h01;
      // RULE13: clock gone means dormant
      if (state_ff.loss == `REF_LOSS_CYC && !state_ff.dormant)
      begin
         nxt_state.dormant = 1'b1;
         nxt_state.locked  = 1'b0;
         nxt_state.edges   = 5'h00;
         // RULE9: powered down, low range
         nxt_state.ctrl[`CTRL_RANGE] = 1'b0;
      end
      // RULE14: amplitude wakes port
      // RULE15: lane0 detector
      if (in0 && state_ff.l0_s2[10] && !state_ff.amp0_d)
      begin
         ev[`INT_WAKE] = 1'b1;
         if (state_ff.dormant)
         begin
            nxt_state.dormant = 1'b0;
            nxt_state.loss    = 6'h00;
            nxt_state.tmr     = 20'h00000;
         end
      end
      // **********
      // Bit clock synthesis and lock
      // **********
      // RULE7: multiplier locks on reference
      if (!state_ff.locked && !state_ff.dormant)
      begin
         if (ref_rise)
            nxt_state.edges = state_ff.edges + 5'h01;
         if (state_ff.edges == `LOCK_EDGES)
         begin
            nxt_state.locked     = 1'b1;
            nxt_state.first_done = 1'b1;
            nxt_state.timed_out  = 1'b0;
            ev[`INT_LOCK]        = 1'b1;
         end
         // RULE11: first lock bound
         if (state_ff.tmr != limit)
            nxt_state.tmr = state_ff.tmr + 20'h00001;
         else if (!state_ff.timed_out)
         begin
            nxt_state.timed_out = 1'b1;
            ev[`INT_TMO]        = 1'b1;
         end
      end
      else
         nxt_state.tmr = 20'h00000;
      // **********
      // Transmit
      // **********
      if (ref_rise && state_ff.locked)
      begin
         nxt_state.oe0 = 1'b0;
         nxt_state.oe1 = 1'b0;
         // RULE13: idle lane when no data
         if (tx_valid_i && out_ok)
         begin
            nxt_state.sym1 = enc1.sym;
            nxt_state.rd1  = enc1.rd;
            nxt_state.oe1  = 1'b1;
            // RULE3: both lanes upstream
            if (hd)
            begin
               nxt_state.sym0 = enc0.sym;
               nxt_state.rd0  = enc0.rd;
               nxt_state.oe0  = 1'b1;
            end
         end
      end
      if (!state_ff.locked)
      begin
         nxt_state.oe0 = 1'b0;
         nxt_state.oe1 = 1'b0;
      end
      // **********
      // Receive
      // **********
      // RULE16: nothing taken before lock
      if (ref_rise && state_ff.locked)
      begin
         if (in0 && state_ff.l0_s2[10])
         begin
            nxt_state.rx_data[7:0] = dec0.data;
            nxt_state.rx_valid[0]  = 1'b1;
            ev[`INT_DERR]          = dec0.err;
         end
         if (in1 && state_ff.l1_s2[10])
         begin
            nxt_state.rx_data[15:8] = dec1.data;
            nxt_state.rx_valid[1]   = 1'b1;
            ev[`INT_DERR]           = ev[`INT_DERR] | dec1.err;
         end
      end
      // **********
      // Register port
      // **********
      if (wr_i)
      begin
         unique case (addr_i)
            `REG_CTRL:
            begin
               nxt_state.ctrl = wdata_i[2:0];
               // RULE8: range change forces relock
               if (wdata_i[`CTRL_RANGE] != state_ff.ctrl[`CTRL_RANGE])
               begin
                  nxt_state.locked = 1'b0;
                  nxt_state.edges  = 5'h00;
               end
            end
            `REG_IEN:  nxt_state.ien = wdata_i[3:0];
            `REG_ICLR: clr = wdata_i[3:0];
            default:   ;
         endcase
      end
      // A clear never swallows an event of the same cycle.
      nxt_state.istat = (state_ff.istat & ~clr) | ev;
      if (rd_i)
      begin
         unique case (addr_i)
            `REG_CTRL:  nxt_state.rdata = {29'h0, state_ff.ctrl};
            `REG_STAT:  nxt_state.rdata = {28'h0, state_ff.first_done,
                                           state_ff.timed_out, state_ff.dormant,
                                           state_ff.locked};
            `REG_ISTAT: nxt_state.rdata = {28'h0, state_ff.istat};
            `REG_IEN:   nxt_state.rdata = {28'h0, state_ff.ien};
            default:    nxt_state.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign link.d_sym0 = state_ff.sym0;
   assign link.d_sym1 = state_ff.sym1;
   assign link.d_oe0  = state_ff.oe0;
   assign link.d_oe1  = state_ff.oe1;
   assign rdata_o     = state_ff.rdata;
   assign irq_o       = |(state_ff.istat & state_ff.ien);
   assign tx_ready_o  = ref_rise & state_ff.locked & out_ok;
   assign rx_data_o   = state_ff.rx_data;
   assign rx_valid_o  = state_ff.rx_valid;
   assign locked_o    = state_ff.locked;
   // RULE8: bit rate ratio
   assign ratio_o     = state_ff.ctrl[`CTRL_RANGE] ? `RATIO_B : `RATIO_A;
endmodule : lane_dev_end
`default_nettype wire

//--- lane_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Properties of the shared lanes
// **********
module lane_asserts
(
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   input wire logic              ref_oe,
   input wire logic              ref_line,
   input wire logic              h_oe0,
   input wire logic              h_oe1,
   input wire logic              d_oe0,
   input wire logic              d_oe1,
   input wire logic              act0,
   input wire logic              act1,
   input wire lane_pkg::sym_type h_sym0,
   input wire lane_pkg::sym_type d_sym1
);
   import lane_pkg::*;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_hd_dn; h_oe1 |-> !(d_oe0 || d_oe1); endproperty
   a_hd_dn: assert property (p_hd_dn) else $error("lane clash down");
   property p_hd_up; d_oe0 |-> !(h_oe0 || h_oe1); endproperty
   a_hd_up: assert property (p_hd_up) else $error("lane clash up");
   property p_ref_fast; $rose(ref_line) |=> (!$rose(ref_line)) [*7]; endproperty
   a_ref_fast: assert property (p_ref_fast) else $error("reference too fast");
   property p_ref_slow; $rose(ref_line) |-> ##[1:8] ($rose(ref_line) || !ref_oe); endproperty
   a_ref_slow: assert property (p_ref_slow) else $error("reference too slow");
   property p_code_h; h_oe0 |-> $countones(h_sym0) inside {[4:6]}; endproperty
   a_code_h: assert property (p_code_h) else $error("host symbol unbalanced");
   property p_code_d; d_oe1 |-> $countones(d_sym1) inside {[4:6]}; endproperty
   a_code_d: assert property (p_code_d) else $error("device symbol unbalanced");
   property p_hold; $changed(h_sym0) && h_oe0 |=> ($stable(h_sym0) || !h_oe0) [*7]; endproperty
   a_hold: assert property (p_hold) else $error("symbol slot short");
   property p_dorm; $fell(ref_oe) |-> ##[0:16] !(act0 || act1); endproperty
   a_dorm: assert property (p_dorm) else $error("lane live while dormant");
endmodule : lane_asserts
`default_nettype wire

//--- test_serial_lane_rate_power_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "lane_cfg.svh"
module test_serial_lane_rate_power_ctrl;
   import lane_pkg::*;
   logic        clk_sys_i = 1'h0, rst_n_i = 1'h0, hd, up, rb, dorm, wr, rd, fail, derr, irq, wk;
   logic        lock[2], txv[2], rdy[2];
   logic [4:0]  adr, rat[2];
   logic [1:0]  rxv[2];
   logic [2:0]  modes[4] = '{3'h0, 3'h4, 3'h5, 3'h7};
   logic [31:0] wd, rdata;
   logic [7:0]  lf = 8'h0B;
   word_type    txd[2], rxd[2], q[2][$];
   int          err_total = 0, num_checks = 0, nw = 0;
   lane_if link();
   lane_host_end #(.LOCK_FIRST_CYC(2000)) u_lane_host_end (.clk_sys_i, .rst_n_i, .link(link),
      .half_duplex_i(hd), .dir_up_i(up), .range_b_i(rb), .dormant_req_i(dorm),
      .tx_data_i(txd[0]), .tx_valid_i(txv[0]), .tx_ready_o(rdy[0]), .rx_data_o(rxd[0]),
      .rx_valid_o(rxv[0]), .rx_err_o(derr), .locked_o(lock[0]), .lock_fail_o(fail),
      .wake_o(wk), .ratio_o(rat[0]));
   lane_dev_end #(.LOCK_CYC(300), .LOCK_FIRST_CYC(2000)) u_lane_dev_end (.clk_sys_i, .rst_n_i,
      .link(link), .addr_i(adr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .irq_o(irq), .tx_data_i(txd[1]), .tx_valid_i(txv[1]), .tx_ready_o(rdy[1]),
      .rx_data_o(rxd[1]), .rx_valid_o(rxv[1]), .locked_o(lock[1]), .ratio_o(rat[1]));
   lane_asserts chk (.clk_sys_i, .rst_n_i, .ref_oe(link.ref_oe), .ref_line(link.ref_line),
      .h_oe0(link.h_oe0), .h_oe1(link.h_oe1), .d_oe0(link.d_oe0), .d_oe1(link.d_oe1),
      .act0(link.act0), .act1(link.act1), .h_sym0(link.h_sym0), .d_sym1(link.d_sym1));
   // **********
   // Helpers
   // **********
   always #50 clk_sys_i = ~clk_sys_i;
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      err_total += int'(g !== e);
      if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
   endtask : ck
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr
   // Full duplex carries one byte a slot, so only the low byte can be expected.
   function automatic word_type seen(input word_type d);
      return hd ? d : {8'h00, d[7:0]};
   endfunction : seen
   always @(negedge clk_sys_i) if (rst_n_i) ck(32'(derr), 32'h0);
   always @(posedge wk) nw++;
   always @(negedge clk_sys_i)
      for (int s = 0; s < 2; s++)
         if (rst_n_i && |rxv[s])
            ck({16'h0, rxv[s][1] ? rxd[s][15:8] : 8'h00, rxv[s][0] ? rxd[s][7:0] : 8'h00},
               q[s].size() > 0 ? {16'h0, q[s].pop_front()} : 32'hX);
   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      {adr, wd, wr} <= {a, d, 1'h1};
      @(posedge clk_sys_i);
      wr <= 1'h0;
   endtask : wreg
   task automatic rreg(input logic [4:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      {adr, rd} <= {a, 1'h1};
      @(posedge clk_sys_i);
      rd <= 1'h0;
      @(negedge clk_sys_i);
      ck(rdata, e);
   endtask : rreg
   task automatic send(input int s, input word_type d);
      int n = 0;
      @(posedge clk_sys_i);
      {txd[s], txv[s]} <= {d, 1'h1};
      do @(negedge clk_sys_i); while (!rdy[s] && ++n < 200);
      @(posedge clk_sys_i);
      txv[s] <= 1'h0;
      q[1 - s].push_back(seen(d));
   endtask : send
   task automatic wt(input int lim);
      int n = 0;
      while ({lock[0], lock[1]} !== 2'h3 && n++ < lim) @(negedge clk_sys_i);
      ck(32'(n <= lim), 32'h1);
   endtask : wt
   task automatic traffic();
      int n = 0;
      for (int i = 0; i < 6; i++)
      begin
         lf = lfsr(lf);
         fork
            if (!(hd && up)) send(0, i > 0 ? {lf, ~lf} : 16'h0000);
            if (!(hd && !up)) send(1, i > 0 ? {~lf, lf} : 16'hFFFF);
         join
      end
      while ((q[0].size() || q[1].size()) && n++ < 100) @(negedge clk_sys_i);
      ck(32'(n <= 100), 32'h1);
      repeat (24) @(posedge clk_sys_i);
   endtask : traffic
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (30000) @(posedge clk_sys_i);
      err_total++;
      test_done();
   end
   // **********
   // Sequence
   // **********
   initial
   begin
      {hd, up, rb, dorm, wr, rd, adr, wd, txv[0], txv[1], txd[0], txd[1]} = '0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'h1;
      rreg(`REG_CTRL, 32'h0);
      ck(32'({rat[0], rat[1]}), 32'({2{`RATIO_A}}));
      wt(2000);
      ck(32'(fail), 32'h0);
      rreg(`REG_STAT, 32'h9);
      rreg(5'h14, 32'h0);
      wreg(`REG_IEN, 32'h4);
      foreach (modes[j])
      begin
         wreg(`REG_CTRL, {29'h0, modes[j]});
         {rb, up, hd} <= modes[j];
         repeat (2) @(posedge clk_sys_i);
         wt(400);
         ck(32'({rat[0], rat[1]}), 32'({2{modes[j][2] ? `RATIO_B : `RATIO_A}}));
         traffic();
      end
      wreg(`REG_ICLR, 32'hF);
      dorm <= 1'h1;
      repeat (100) @(posedge clk_sys_i);
      ck(32'({rat[0], rat[1], lock[0], lock[1]}), 32'({{2{`RATIO_A}}, 2'h0}));
      rreg(`REG_STAT, 32'hA);
      wreg(`REG_CTRL, 32'h0);
      {rb, up, hd, dorm} <= 4'h0;
      wt(400);
      rreg(`REG_ISTAT, 32'h5);
      ck(32'(irq), 32'h1);
      wreg(`REG_ICLR, 32'h4);
      rreg(`REG_ISTAT, 32'h1);
      ck(32'(irq), 32'h0);
      traffic();
      ck(32'(nw > 0), 32'h1);
      test_done();
   end
endmodule : test_serial_lane_rate_power_ctrl
`default_nettype wire
